// ---- design/status_regs_defs.vh ----
// register offsets, field positions, reset values and timing for the status register bank
`ifndef STATUS_REGS_DEFS_VH
`define STATUS_REGS_DEFS_VH

// register offsets
`define ADDR_TICK          8'h00
`define ADDR_SUMMARY       8'h01
`define ADDR_SUPPLY        8'h02
`define ADDR_MEMTEMP       8'h03
`define ADDR_LINK          8'h04

// summary_status fields
`define SUM_DSP            7
`define SUM_LINK           5
`define SUM_MEMTEMP        4
`define SUM_SUPPLY         3
`define SUM_TEST           2
`define SUM_RESET          1
`define SUM_INIT           0

// supply_status fields
`define SUP_UV             7
`define SUP_ANALOG         3
`define SUP_DIGITAL        2
`define SUP_OTPREG         1
`define SUP_SEAL           0

// memory_temp_status fields
`define MT_FACTORY_OTP     7
`define MT_USER_OTP        6
`define MT_USER_REG        5
`define MT_WRITE_ACTIVE    4
`define MT_TEMP            2

// link_status fields
`define LINK_MISMATCH      7

// reset values
`define TICK_RESET         8'h00
`define MEMTEMP_RESET      8'h00
`define LINK_RESET         8'h00
`define SUPPLY_RESET       5'h00
`define RD_DATA_RESET      8'h00

// timing: system clock, primary oscillator, prescaler, delays
`define CLK_PERIOD_PS      4000
`define OSC_PERIOD_PS      100000
`define PRESCALE_DIV       1000
`define TICK_PERIOD_US     100
`define SUPPLY_RCV_TIME_NS 10000
`define DATA_VALID_NS      20000
`define OSC_DIV_CYCLES     (`OSC_PERIOD_PS / `CLK_PERIOD_PS)
`define SUPPLY_RCV_CYCLES  ((`SUPPLY_RCV_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define DATA_VALID_CYCLES  ((`DATA_VALID_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ---- design/tick_counter_core.v ----
// free-running tick counter behind an oscillator enable and a divide-by-1000 prescaler
`include "status_regs_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module tick_counter_core #(
   parameter OSC_DIV  = 25,
   parameter PRESCALE = 1000,
   parameter PRE_W    = 10,
   parameter WIDTH    = 8
) (
   input  wire             clk,
   input  wire             dev_rst,
   output reg  [WIDTH-1:0] count_reg
);
   localparam OSC_W = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
   localparam integer     OSC_LAST_I = OSC_DIV - 1;
   localparam integer     PRE_LAST_I = PRESCALE - 1;
   localparam [OSC_W-1:0] OSC_LAST   = OSC_LAST_I[OSC_W-1:0];
   localparam [PRE_W-1:0] PRE_LAST   = PRE_LAST_I[PRE_W-1:0];

   reg  [OSC_W-1:0] osc_cnt_reg;
   reg  [PRE_W-1:0] pre_cnt_reg;
   reg              osc_en_reg;
   wire             tick_en;

   // oscillator-rate enable pulse from the system clock
   always @(posedge clk) begin
      if (dev_rst) begin
         osc_cnt_reg <= {OSC_W{1'b0}};
         osc_en_reg  <= 1'b0;
      end else if (osc_cnt_reg == OSC_LAST) begin
         osc_cnt_reg <= {OSC_W{1'b0}};
         osc_en_reg  <= 1'b1;
      end else begin
         osc_cnt_reg <= osc_cnt_reg + 1'b1;
         osc_en_reg  <= 1'b0;
      end
   end

   assign tick_en = osc_en_reg && (pre_cnt_reg == PRE_LAST);

   // prescaler divides the oscillator by 1000; counter wraps after 255
   always @(posedge clk) begin
      if (dev_rst) begin
         pre_cnt_reg <= {PRE_W{1'b0}};
         count_reg   <= `TICK_RESET;
      end else if (osc_en_reg) begin
         pre_cnt_reg <= (pre_cnt_reg == PRE_LAST) ? {PRE_W{1'b0}} : pre_cnt_reg + 1'b1;
         if (tick_en)
            count_reg <= count_reg + 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- design/supply_status_core.v ----
// supply fault flags held by one shared recovery timer
`include "status_regs_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module supply_status_core #(
   parameter RCV_CYCLES = 2500,
   parameter CNT_W      = 12
) (
   input  wire       clk,
   input  wire       dev_rst,
   input  wire [4:0] mon,
   input  wire       report_disable,
   output reg  [4:0] flags_reg,
   output reg        any_reg
);
   localparam integer     RCV_LOAD_I = RCV_CYCLES;
   localparam [CNT_W-1:0] RCV_LOAD   = RCV_LOAD_I[CNT_W-1:0];

   reg  [CNT_W-1:0] timer_reg;
   wire             src_any;
   wire             hold;
   reg  [4:0]       flags_next;

   assign src_any = |mon;
   assign hold    = (timer_reg != {CNT_W{1'b0}});

   // flags follow the monitors; hold until the timer runs out unless disabled
   always @* begin
      if (report_disable)
         flags_next = mon;
      else
         flags_next = mon | (flags_reg & {5{hold}});
   end

   // shared recovery timer, reloaded while any fault is present
   always @(posedge clk) begin
      if (dev_rst) begin
         timer_reg <= {CNT_W{1'b0}};
         flags_reg <= `SUPPLY_RESET;
         any_reg   <= 1'b0;
      end else begin
         if (src_any)
            timer_reg <= RCV_LOAD;
         else if (hold)
            timer_reg <= timer_reg - 1'b1;
         flags_reg <= flags_next;
         any_reg   <= |flags_next;
      end
   end
endmodule
`default_nettype wire

// ---- design/status_tick_regs.v ----
// read-only status and tick counter register bank of the pressure sensor
//
// Overview of operation
// - free-running 8-bit tick counter, 100 us step
// - 10-bit prescaler divides oscillator by 1000
// - all status registers read-only on either interface
// - summary bit 7 ORs three filter flags
// - summary bit 5 set by any link bit
// - summary bit 4 ORs five memory/temperature flags
// - summary bit 3 ORs five supply flags
// - summary bit 2 shows test mode, sticky
// - summary bit 1 set on reset, read clears
// - summary bit 0 set until data valid
// - supply bit 7 reports supply undervoltage
// - supply bit 3 reports analog regulator fault
// - supply bit 2 reports digital regulator fault
// - supply bit 1 reports OTP regulator fault
// - supply bit 0 reports edge seal break
// - shared recovery timer, clearing per disable bit
// - link bit 7 mismatch, cleared by read/transmission
// - memory/temperature errors cleared by read/transmission
// - OTP write active follows write in progress
`include "status_regs_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module status_tick_regs #(
   parameter OSC_DIV_CYCLES    = `OSC_DIV_CYCLES,
   parameter PRESCALE_DIV      = `PRESCALE_DIV,
   parameter SUPPLY_RCV_CYCLES = `SUPPLY_RCV_CYCLES,
   parameter DATA_VALID_CYCLES = `DATA_VALID_CYCLES,
   parameter TIMER_W           = 16
) (
   input  wire       CLK_SYS,
   input  wire       SRST,
   input  wire       SOFT_RESET,
   // register read and write requests
   input  wire       RD_EN,
   input  wire [7:0] RD_ADDR,
   input  wire       WR_EN,
   input  wire [7:0] WR_ADDR,
   // clears from outgoing status fields
   input  wire       TX_SUMMARY_CLR,
   input  wire       TX_MEMTEMP_CLR,
   input  wire       TX_LINK_CLR,
   // filter flags and test mode operations
   input  wire       SELFTEST_INCOMPLETE,
   input  wire       COMMON_MODE_FAULT,
   input  wire       SELFTEST_FAULT,
   input  wire       TEST_MODE_ENTER,
   input  wire       TEST_MODE_EXIT,
   // supply monitors and their report control
   input  wire       SUPPLY_UV_MON,
   input  wire       ANALOG_REG_MON,
   input  wire       DIGITAL_REG_MON,
   input  wire       OTP_REG_MON,
   input  wire       EDGE_SEAL_MON,
   input  wire       SUPPLY_REPORT_DISABLE,
   // memory and temperature error sources
   input  wire       FACTORY_OTP_FAULT,
   input  wire       USER_OTP_FAULT,
   input  wire       USER_REG_CHECK_FAULT,
   input  wire       OTP_WRITE_BUSY,
   input  wire       TEMPERATURE_FAULT,
   // link error source
   input  wire       READBACK_MISMATCH,
   // read answer, write refusal, status field copy
   output reg  [7:0] RD_DATA,
   output reg        RD_VALID,
   output reg        WR_IGNORED,
   output reg  [7:0] SUMMARY_STATUS
);
   // init sequence states
   localparam [2:0] ST_IDLE  = 3'b001;
   localparam [2:0] ST_WAIT  = 3'b010;
   localparam [2:0] ST_READY = 3'b100;

   // last count of the data-valid delay, cut to the timer width
   localparam integer       DV_LAST_I = DATA_VALID_CYCLES - 1;
   localparam [TIMER_W-1:0] DV_LAST   = DV_LAST_I[TIMER_W-1:0];

   // recovery timer width, room for the full reload value
   localparam RCV_W = $clog2(SUPPLY_RCV_CYCLES + 1);

   // true when an address lands on one of this bank's registers
   function is_bank_addr;
      input [7:0] a;
      begin
         if (a == `ADDR_TICK)
            is_bank_addr = 1'b1;
         else if (a == `ADDR_SUMMARY)
            is_bank_addr = 1'b1;
         else if (a == `ADDR_SUPPLY)
            is_bank_addr = 1'b1;
         else if (a == `ADDR_MEMTEMP)
            is_bank_addr = 1'b1;
         else if (a == `ADDR_LINK)
            is_bank_addr = 1'b1;
         else
            is_bank_addr = 1'b0;
      end
   endfunction

   // reset and submodule results
   wire             dev_rst;
   wire [7:0]       tick_count;
   wire [4:0]       supply_flags;
   wire             supply_any;
   wire [4:0]       supply_mon;

   // read strobes and error events
   wire             rd_summary;
   wire             rd_memtemp;
   wire             rd_link;
   wire             clr_memtemp;
   wire [3:0]       mt_evt;

   // group summaries
   wire             dsp_any;
   wire             memtemp_any;
   wire             link_any;

   // status flags
   reg  [3:0]       mt_err_reg;
   reg              mt_busy_reg;
   reg              link_mismatch_reg;
   reg              reset_occurred_reg;
   reg              test_state_reg;
   reg              init_pending_reg;

   // init sequence
   reg  [2:0]       init_state_reg;
   reg  [2:0]       init_state_next;
   reg  [TIMER_W-1:0] dv_cnt_reg;

   // register images and read select
   reg  [7:0]       supply_byte;
   reg  [7:0]       memtemp_byte;
   reg  [7:0]       link_byte;
   reg  [7:0]       summary_byte;
   reg  [7:0]       rd_mux;

   // soft reset acts as a device reset for everything but test mode and the registered outputs
   assign dev_rst = SRST | SOFT_RESET;

   // tick counter with its oscillator divider and prescaler
   tick_counter_core #(
      .OSC_DIV  (OSC_DIV_CYCLES),
      .PRESCALE (PRESCALE_DIV),
      .PRE_W    (10),
      .WIDTH    (8)
   ) u_tick (
      .clk       (CLK_SYS),
      .dev_rst   (dev_rst),
      .count_reg (tick_count)
   );

   // monitor levels in supply flag order
   assign supply_mon = {SUPPLY_UV_MON, ANALOG_REG_MON, DIGITAL_REG_MON,
                        OTP_REG_MON, EDGE_SEAL_MON};

   // supply flags with shared recovery timer
   supply_status_core #(
      .RCV_CYCLES (SUPPLY_RCV_CYCLES),
      .CNT_W      (RCV_W)
   ) u_supply (
      .clk            (CLK_SYS),
      .dev_rst        (dev_rst),
      .mon            (supply_mon),
      .report_disable (SUPPLY_REPORT_DISABLE),
      .flags_reg      (supply_flags),
      .any_reg        (supply_any)
   );

   // read strobes that carry a clear side effect
   assign rd_summary  = RD_EN && (RD_ADDR == `ADDR_SUMMARY);
   assign rd_memtemp  = RD_EN && (RD_ADDR == `ADDR_MEMTEMP);
   assign rd_link     = RD_EN && (RD_ADDR == `ADDR_LINK);
   assign clr_memtemp = rd_memtemp | TX_MEMTEMP_CLR;

   // sticky memory/temperature error sources: factory, user otp, user reg, temp
   assign mt_evt = {FACTORY_OTP_FAULT, USER_OTP_FAULT, USER_REG_CHECK_FAULT,
                    TEMPERATURE_FAULT};

   // one sticky flag per error source; a new event wins over the clear
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_mt_flag
         always @(posedge CLK_SYS) begin
            if (dev_rst)
               mt_err_reg[gi] <= 1'b0;
            else
               mt_err_reg[gi] <= mt_evt[gi] | (mt_err_reg[gi] & ~clr_memtemp);
         end
      end
   endgenerate

   // write-active mirrors the write in progress, clears by itself
   always @(posedge CLK_SYS) begin
      if (dev_rst)
         mt_busy_reg <= 1'b0;
      else
         mt_busy_reg <= OTP_WRITE_BUSY;
   end

   // readback mismatch flag, cleared by read or status transmission
   always @(posedge CLK_SYS) begin
      if (dev_rst)
         link_mismatch_reg <= 1'b0;
      else
         link_mismatch_reg <= READBACK_MISMATCH |
                              (link_mismatch_reg & ~(rd_link | TX_LINK_CLR));
   end

   // reset-occurred flag: set by reset, cleared by read or transmission
   always @(posedge CLK_SYS) begin
      if (dev_rst)
         reset_occurred_reg <= 1'b1;
      else if (rd_summary | TX_SUMMARY_CLR)
         reset_occurred_reg <= 1'b0;
   end

   // test mode survives soft reset; only power cycle or test op clears it
   always @(posedge CLK_SYS) begin
      if (SRST)
         test_state_reg <= 1'b0;
      else if (TEST_MODE_ENTER)
         test_state_reg <= 1'b1;
      else if (TEST_MODE_EXIT)
         test_state_reg <= 1'b0;
   end

   // init sequence: hold init pending until the data-valid delay passes
   always @* begin
      init_state_next = init_state_reg;
      case (init_state_reg)
         ST_IDLE: begin
            init_state_next = ST_WAIT;
         end
         ST_WAIT: begin
            if (dv_cnt_reg == DV_LAST)
               init_state_next = ST_READY;
         end
         ST_READY: begin
            init_state_next = ST_READY;
         end
         default: begin
            init_state_next = ST_IDLE;
         end
      endcase
   end

   // data-valid delay counter and init pending flag
   always @(posedge CLK_SYS) begin
      if (dev_rst) begin
         init_state_reg   <= ST_IDLE;
         dv_cnt_reg       <= {TIMER_W{1'b0}};
         init_pending_reg <= 1'b1;
      end else begin
         init_state_reg <= init_state_next;
         if (init_state_reg == ST_WAIT)
            dv_cnt_reg <= dv_cnt_reg + 1'b1;
         init_pending_reg <= (init_state_next != ST_READY);
      end
   end

   // group summaries, recomputed every cycle from their sources
   assign dsp_any     = SELFTEST_INCOMPLETE | COMMON_MODE_FAULT | SELFTEST_FAULT;
   assign memtemp_any = (|mt_err_reg) | mt_busy_reg;
   assign link_any    = |link_byte;

   // assemble supply, memory/temperature and link register images
   always @* begin
      supply_byte                    = 8'h00;
      supply_byte[`SUP_UV]           = supply_flags[4];
      supply_byte[`SUP_ANALOG]       = supply_flags[3];
      supply_byte[`SUP_DIGITAL]      = supply_flags[2];
      supply_byte[`SUP_OTPREG]       = supply_flags[1];
      supply_byte[`SUP_SEAL]         = supply_flags[0];
      memtemp_byte                   = `MEMTEMP_RESET;
      memtemp_byte[`MT_FACTORY_OTP]  = mt_err_reg[3];
      memtemp_byte[`MT_USER_OTP]     = mt_err_reg[2];
      memtemp_byte[`MT_USER_REG]     = mt_err_reg[1];
      memtemp_byte[`MT_WRITE_ACTIVE] = mt_busy_reg;
      memtemp_byte[`MT_TEMP]         = mt_err_reg[0];
      link_byte                      = `LINK_RESET;
      link_byte[`LINK_MISMATCH]      = link_mismatch_reg;
   end

   // summary register image; bit 6 reserved, reads zero
   always @* begin
      summary_byte               = 8'h00;
      summary_byte[`SUM_DSP]     = dsp_any;
      summary_byte[`SUM_LINK]    = link_any;
      summary_byte[`SUM_MEMTEMP] = memtemp_any;
      summary_byte[`SUM_SUPPLY]  = supply_any;
      summary_byte[`SUM_TEST]    = test_state_reg;
      summary_byte[`SUM_RESET]   = reset_occurred_reg;
      summary_byte[`SUM_INIT]    = init_pending_reg;
   end

   // read data select; unmapped addresses read zero
   always @* begin
      if (RD_ADDR == `ADDR_TICK)
         rd_mux = tick_count;
      else if (RD_ADDR == `ADDR_SUMMARY)
         rd_mux = summary_byte;
      else if (RD_ADDR == `ADDR_SUPPLY)
         rd_mux = supply_byte;
      else if (RD_ADDR == `ADDR_MEMTEMP)
         rd_mux = memtemp_byte;
      else if (RD_ADDR == `ADDR_LINK)
         rd_mux = link_byte;
      else
         rd_mux = 8'h00;
   end

   // registered read answer, value captured before any clear
   always @(posedge CLK_SYS) begin
      if (SRST) begin
         RD_DATA  <= `RD_DATA_RESET;
         RD_VALID <= 1'b0;
      end else begin
         RD_VALID <= RD_EN;
         if (RD_EN)
            RD_DATA <= rd_mux;
      end
   end

   // writes change nothing here; a hit on the bank is reported
   always @(posedge CLK_SYS) begin
      if (SRST)
         WR_IGNORED <= 1'b0;
      else
         WR_IGNORED <= WR_EN && is_bank_addr(WR_ADDR);
   end

   // summary image also driven out for the data-frame status field
   always @(posedge CLK_SYS) begin
      if (SRST)
         SUMMARY_STATUS <= 8'h00;
      else
         SUMMARY_STATUS <= summary_byte;
   end
endmodule
`default_nettype wire

// ---- dv/status_tick_regs_checker.sv ----
// concurrent checks on the ports of the status and tick register bank
`timescale 1ns/1ps
`default_nettype none
module status_tick_regs_checker (
   input wire logic       CLK_SYS,
   input wire logic       SRST,
   input wire logic       RD_EN,
   input wire logic [7:0] RD_ADDR,
   input wire logic       WR_EN,
   input wire logic [7:0] WR_ADDR,
   input wire logic       TX_LINK_CLR,
   input wire logic       SELFTEST_INCOMPLETE,
   input wire logic       COMMON_MODE_FAULT,
   input wire logic       SELFTEST_FAULT,
   input wire logic       TEST_MODE_ENTER,
   input wire logic       SUPPLY_UV_MON,
   input wire logic       ANALOG_REG_MON,
   input wire logic       DIGITAL_REG_MON,
   input wire logic       OTP_REG_MON,
   input wire logic       EDGE_SEAL_MON,
   input wire logic       READBACK_MISMATCH,
   input wire logic [7:0] RD_DATA,
   input wire logic       RD_VALID,
   input wire logic       WR_IGNORED,
   input wire logic [7:0] SUMMARY_STATUS
);
   // group causes seen at the inputs
   wire filt = SELFTEST_INCOMPLETE | COMMON_MODE_FAULT | SELFTEST_FAULT;
   wire mon  = SUPPLY_UV_MON | ANALOG_REG_MON | DIGITAL_REG_MON | OTP_REG_MON | EDGE_SEAL_MON;
   wire lclr = (RD_EN && RD_ADDR == 8'h04) || TX_LINK_CLR;

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SRST);

   a_read_answer: assert property (RD_EN |=> RD_VALID)
      else $error("read not answered");
   a_valid_pulse: assert property (!RD_EN |=> !RD_VALID)
      else $error("valid without read");
   a_rd_data_hold: assert property (!RD_EN |=> $stable(RD_DATA))
      else $error("read data moved");
   a_write_ignored: assert property (WR_EN && WR_ADDR <= 8'h04 |=> WR_IGNORED)
      else $error("write not refused");
   a_write_quiet: assert property (!(WR_EN && WR_ADDR <= 8'h04) |=> !WR_IGNORED)
      else $error("spurious write refusal");
   a_filter_or_set: assert property (filt |=> SUMMARY_STATUS[7])
      else $error("filter group not set");
   a_filter_or_clr: assert property (!filt |=> !SUMMARY_STATUS[7])
      else $error("filter group stuck");
   a_link_set: assert property (READBACK_MISMATCH |=> ##1 SUMMARY_STATUS[5])
      else $error("link group not set");
   a_link_clear: assert property (lclr && !READBACK_MISMATCH |=> ##1 !SUMMARY_STATUS[5])
      else $error("link flag not cleared");
   a_supply_group: assert property (mon |=> ##1 SUMMARY_STATUS[3])
      else $error("supply group not set");
   a_test_enter: assert property (TEST_MODE_ENTER |=> ##1 SUMMARY_STATUS[2])
      else $error("test flag not set");
   a_reset_flags: assert property ($fell(SRST) |=> SUMMARY_STATUS[1:0] == 2'b11)
      else $error("reset and init flags not set");

   c_summary_read: cover property (RD_EN && RD_ADDR == 8'h01);
   c_write_refused: cover property (WR_IGNORED);
   c_supply_fault: cover property (SUMMARY_STATUS[3]);
endmodule

bind status_tick_regs status_tick_regs_checker i_status_tick_regs_checker (
   .CLK_SYS(CLK_SYS), .SRST(SRST), .RD_EN(RD_EN), .RD_ADDR(RD_ADDR), .WR_EN(WR_EN),
   .WR_ADDR(WR_ADDR), .TX_LINK_CLR(TX_LINK_CLR), .SELFTEST_INCOMPLETE(SELFTEST_INCOMPLETE),
   .COMMON_MODE_FAULT(COMMON_MODE_FAULT), .SELFTEST_FAULT(SELFTEST_FAULT),
   .TEST_MODE_ENTER(TEST_MODE_ENTER), .SUPPLY_UV_MON(SUPPLY_UV_MON),
   .ANALOG_REG_MON(ANALOG_REG_MON), .DIGITAL_REG_MON(DIGITAL_REG_MON),
   .OTP_REG_MON(OTP_REG_MON), .EDGE_SEAL_MON(EDGE_SEAL_MON),
   .READBACK_MISMATCH(READBACK_MISMATCH), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
   .WR_IGNORED(WR_IGNORED), .SUMMARY_STATUS(SUMMARY_STATUS));
`default_nettype wire

// ---- dv/host_model.sv ----
// host side model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic       clk,
   input  wire logic       rd_valid,
   input  wire logic [7:0] rd_data,
   input  wire logic       wr_ignored,
   output var  logic       rd_en,
   output var  logic [7:0] rd_addr,
   output var  logic       wr_en,
   output var  logic [7:0] wr_addr
);
   // idle bus at time zero
   initial begin
      rd_en   = 1'b0;
      rd_addr = 8'h00;
      wr_en   = 1'b0;
      wr_addr = 8'h00;
   end

   // one read, answer taken one edge after the request
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge clk);
      rd_en   <= 1'b1;
      rd_addr <= a;
      @(posedge clk);
      rd_en   <= 1'b0;
      rd_addr <= ~a; // released address no longer shows the old value
      #1;
      d = rd_data;
      v = rd_valid;
   endtask

   // one write attempt, refusal taken one edge later
   task automatic wr(input logic [7:0] a, output logic ign);
      @(posedge clk);
      wr_en   <= 1'b1;
      wr_addr <= a;
      @(posedge clk);
      wr_en   <= 1'b0;
      wr_addr <= ~a;
      #1;
      ign = wr_ignored;
   endtask
endmodule
`default_nettype wire

// ---- dv/status_tick_regs_tb.sv ----
// self-checking bench for the status and tick register bank
`timescale 1ns/1ps
`default_nettype none
module status_tick_regs_tb;
   logic       clk, srst, soft_rst, tx_sum, tx_mt, tx_lk, t_enter, t_exit, sup_dis, busy, mis;
   logic [2:0] fil;
   logic [4:0] mon;
   logic [3:0] mt_src;
   wire        rd_en, wr_en, rd_valid, wr_ign;
   wire  [7:0] rd_addr, wr_addr, rd_data, summ;
   int         miscompares, n_compared, seed;
   logic [7:0] t0, d, mt, sup;
   logic       v, rst_f, init_f, test_f, lk;

   status_tick_regs #(.OSC_DIV_CYCLES(2), .PRESCALE_DIV(4), .SUPPLY_RCV_CYCLES(8),
      .DATA_VALID_CYCLES(10), .TIMER_W(16)) i_status_tick_regs (
      .CLK_SYS(clk), .SRST(srst), .SOFT_RESET(soft_rst), .RD_EN(rd_en), .RD_ADDR(rd_addr),
      .WR_EN(wr_en), .WR_ADDR(wr_addr), .TX_SUMMARY_CLR(tx_sum), .TX_MEMTEMP_CLR(tx_mt),
      .TX_LINK_CLR(tx_lk), .SELFTEST_INCOMPLETE(fil[0]), .COMMON_MODE_FAULT(fil[1]),
      .SELFTEST_FAULT(fil[2]), .TEST_MODE_ENTER(t_enter), .TEST_MODE_EXIT(t_exit),
      .SUPPLY_UV_MON(mon[4]), .ANALOG_REG_MON(mon[3]), .DIGITAL_REG_MON(mon[2]),
      .OTP_REG_MON(mon[1]), .EDGE_SEAL_MON(mon[0]), .SUPPLY_REPORT_DISABLE(sup_dis),
      .FACTORY_OTP_FAULT(mt_src[0]), .USER_OTP_FAULT(mt_src[1]),
      .USER_REG_CHECK_FAULT(mt_src[2]), .OTP_WRITE_BUSY(busy), .TEMPERATURE_FAULT(mt_src[3]),
      .READBACK_MISMATCH(mis), .RD_DATA(rd_data), .RD_VALID(rd_valid), .WR_IGNORED(wr_ign),
      .SUMMARY_STATUS(summ));

   host_model i_host_model (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data),
      .wr_ignored(wr_ign), .rd_en(rd_en), .rd_addr(rd_addr), .wr_en(wr_en), .wr_addr(wr_addr));

   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // summary byte predicted from the model state
   function automatic logic [7:0] exp_sum();
      return {|fil, 1'b0, lk, (mt | {3'h0, busy, 4'h0}) != 8'h00, sup != 8'h00,
              test_f, rst_f, init_f};
   endfunction

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
      end
   endtask

   // read a register, compare with the model, then apply read side effects
   task automatic rr(input logic [7:0] a);
      i_host_model.rd(a, d, v);
      cmp_bit(v, 1'b1);
      case (a)
         8'h01:   cmp(d, exp_sum());
         8'h02:   cmp(d, sup);
         8'h03:   cmp(d, mt | {3'h0, busy, 4'h0});
         8'h04:   cmp(d, {lk, 7'h00});
         default: cmp(d, 8'h00);
      endcase
      if (a == 8'h01) rst_f = 1'b0;
      if (a == 8'h03) mt = 8'h00;
      if (a == 8'h04) lk = 1'b0;
   endtask

   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // watchdog
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      end_sim();
   end

   initial begin
      {srst, soft_rst, tx_sum, tx_mt, tx_lk, t_enter, t_exit, busy, mis} = 9'h100;
      {sup_dis, fil, mon, mt_src} = 13'h1000;
      {mt, sup, lk, test_f, rst_f, init_f} = 20'h00003;
      seed = $urandom(32'h3597);
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      rr(8'h00);
      rr(8'h01);
      rr(8'h01);
      rr(8'h07);
      // tick spacing of 259 steps with a refused write in between
      i_host_model.rd(8'h00, t0, v);
      i_host_model.wr(8'h00, v);
      cmp_bit(v, 1'b1);
      repeat (8 * 259 - 4) @(posedge clk);
      i_host_model.rd(8'h00, d, v);
      cmp(d, t0 + 8'h03);
      init_f = 1'b0;
      for (int a = 1; a < 6; a++) begin
         i_host_model.wr(8'(a), v);
         cmp_bit(v, a < 5);
      end
      repeat (8) begin
         @(posedge clk) fil <= 3'($urandom);
         rr(8'h01);
      end
      @(posedge clk) fil <= 3'h0;
      // sticky memory and temperature errors, cleared by read or frame
      for (int k = 0; k < 4; k++) begin
         @(posedge clk) mt_src <= 4'h1 << k;
         @(posedge clk) mt_src <= 4'h0;
         mt = (k == 3) ? 8'h04 : 8'h80 >> k;
         rr(8'h01);
         if (k[0]) begin
            @(posedge clk) tx_mt <= 1'b1;
            @(posedge clk) tx_mt <= 1'b0;
            mt = 8'h00;
         end
         rr(8'h03);
         rr(8'h03);
         rr(8'h01);
      end
      @(posedge clk) busy <= 1'b1;
      rr(8'h03);
      rr(8'h01);
      @(posedge clk) busy <= 1'b0;
      rr(8'h01);
      // readback mismatch cleared by read, then by status frame
      @(posedge clk) mis <= 1'b1;
      @(posedge clk) mis <= 1'b0;
      lk = 1'b1;
      rr(8'h01);
      rr(8'h04);
      rr(8'h04);
      @(posedge clk) mis <= 1'b1;
      @(posedge clk) mis <= 1'b0;
      @(posedge clk) tx_lk <= 1'b1;
      @(posedge clk) tx_lk <= 1'b0;
      rr(8'h04);
      // each supply monitor with reporting that follows the monitors
      for (int k = 0; k < 5; k++) begin
         @(posedge clk) mon <= 5'h01 << k;
         sup = (k < 4) ? 8'h01 << k : 8'h80;
         rr(8'h02);
         rr(8'h01);
         @(posedge clk) mon <= 5'h00;
         sup = 8'h00;
         rr(8'h02);
      end
      // recovery timer holds the flag after the monitor drops
      @(posedge clk) sup_dis <= 1'b0;
      @(posedge clk) mon <= 5'h10;
      sup = 8'h80;
      rr(8'h02);
      @(posedge clk) mon <= 5'h00;
      rr(8'h02);
      repeat (12) @(posedge clk);
      sup = 8'h00;
      rr(8'h02);
      // test mode survives soft reset, leaves by exit operation
      @(posedge clk) t_enter <= 1'b1;
      @(posedge clk) t_enter <= 1'b0;
      test_f = 1'b1;
      rr(8'h01);
      @(posedge clk) soft_rst <= 1'b1;
      @(posedge clk) soft_rst <= 1'b0;
      {rst_f, init_f} = 2'b11;
      rr(8'h01);
      repeat (20) @(posedge clk);
      init_f = 1'b0;
      rr(8'h01);
      @(posedge clk) t_exit <= 1'b1;
      @(posedge clk) t_exit <= 1'b0;
      test_f = 1'b0;
      rr(8'h01);
      // power cycle clears test mode; frame clears the reset flag
      @(posedge clk) t_enter <= 1'b1;
      @(posedge clk) t_enter <= 1'b0;
      @(posedge clk) srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      {test_f, rst_f, init_f} = 3'b011;
      @(posedge clk) tx_sum <= 1'b1;
      @(posedge clk) tx_sum <= 1'b0;
      rst_f = 1'b0;
      rr(8'h01);
      end_sim();
   end
endmodule
`default_nettype wire
